// *** hw/tcie_consts.svh ***
`ifndef TCIE_CONSTS_SVH
`define TCIE_CONSTS_SVH

// register byte offsets
`define TCIE_OFF_CONTROL 12'h000
`define TCIE_OFF_IRQ_EN 12'h00c
`define TCIE_OFF_STATUS 12'h010
`define TCIE_OFF_EVENT 12'h014
`define TCIE_OFF_PRESCALER 12'h028
`define TCIE_OFF_RELOAD 12'h02c
`define TCIE_OFF_COUNT 12'h024
`define TCIE_OFF_COMPARE1 12'h034

// control field positions
`define TCIE_CTL_RUN_BIT 0
`define TCIE_CTL_NOUPD_BIT 1
`define TCIE_CTL_USRC_BIT 2
`define TCIE_CTL_RBUF_BIT 7
`define TCIE_CTL_DIV_LO 8
`define TCIE_CTL_DIV_HI 9
`define TCIE_CTL_MASK 16'h0387

// interrupt enable / status / event positions
`define TCIE_UPD_BIT 0
`define TCIE_CH1_BIT 1
`define TCIE_IRQ_MASK 16'h0003

// reset values
`define TCIE_RST_CONTROL 16'h0000
`define TCIE_RST_IRQ_EN 16'h0000
`define TCIE_RST_VALUE16 16'h0000

// filter divide encodings
`define TCIE_DIV1 2'h0
`define TCIE_DIV2 2'h1
`define TCIE_DIV4 2'h2

`endif

// *** hw/tcie_pkg.sv ***
package tcie_pkg;

    typedef struct packed {
        logic [1:0] filter_clock_divide;
        logic reload_buffer_enable;
        logic update_source_select;
        logic update_disable;
        logic counter_enable;
    } tcie_ctl_t;

    typedef struct packed {
        logic channel1_irq_enable;
        logic update_irq_enable;
    } tcie_ien_t;

    typedef struct packed {
        logic sel;
        logic write;
        logic [11:0] addr;
        logic [2:0] size;
    } tcie_aphase_t;

    typedef enum logic [1:0] {
        TCIE_BUS_IDLE = 2'b01,
        TCIE_BUS_DATA = 2'b10
    } tcie_bus_state_t;

    typedef struct packed {
        logic update_event;
        logic soft_restart;
        logic sample_tick;
    } tcie_evt_t;

endpackage

// *** hw/tcie_sample_div.sv ***
`timescale 1ns/100ps
`include "tcie_consts.svh"

// filter sampling tick generator: one tick every 1, 2 or 4 timer clocks
module tcie_sample_div
    import tcie_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst_b,
    input wire logic clk_en,
    input wire logic [1:0] filter_clock_divide,
    output logic sample_tick
);

    typedef struct packed {
        logic [1:0] cnt;
        logic tick;
    } tcie_div_state_t;

    tcie_div_state_t st;
    tcie_div_state_t next_st;

    function automatic logic [1:0] div_last(input logic [1:0] sel);
        unique case (sel)
            `TCIE_DIV2: div_last = 2'h1;
            `TCIE_DIV4: div_last = 2'h3;
            default: div_last = 2'h0;
        endcase
    endfunction

    always_comb begin
        next_st = st;
        if (st.cnt >= div_last(filter_clock_divide)) begin
            next_st.cnt = 2'h0;
            next_st.tick = 1'b1;
        end else begin
            next_st.cnt = st.cnt + 2'h1;
            next_st.tick = 1'b0;
        end
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            st <= '0;
        end else if (clk_en) begin
            st <= next_st;
        end
    end

    assign sample_tick = st.tick;

    div4_period_a: assert property (@(posedge core_clk) disable iff (!rst_b)
        (clk_en && filter_clock_divide == `TCIE_DIV4 && $stable(filter_clock_divide)
         && sample_tick) ##1 (clk_en && $stable(filter_clock_divide))
         ##1 (clk_en && $stable(filter_clock_divide)) |-> !sample_tick)
        else $error("tick too soon for divide by four");

endmodule

// *** hw/tcie_time_base.sv ***
`timescale 1ns/100ps
`include "tcie_consts.svh"

// prescaler and counter with buffered reload, prescaler and compare
module tcie_time_base
    import tcie_pkg::*;
#(
    parameter int WIDTH = 16
)
(
    input wire logic core_clk,
    input wire logic rst_b,
    input wire logic clk_en,
    input wire logic counter_enable,
    input wire logic reload_buffer_enable,
    input wire logic update_event,
    input wire logic soft_restart,
    input wire logic [WIDTH-1:0] reload_pre,
    input wire logic [WIDTH-1:0] prescale_pre,
    input wire logic [WIDTH-1:0] compare_pre,
    output logic overflow,
    output logic compare_hit,
    output logic [WIDTH-1:0] count
);

    typedef struct packed {
        logic [WIDTH-1:0] pre_cnt;
        logic [WIDTH-1:0] cnt;
        logic [WIDTH-1:0] reload_act;
        logic [WIDTH-1:0] pre_act;
        logic [WIDTH-1:0] cmp_act;
    } tcie_tb_state_t;

    tcie_tb_state_t st;
    tcie_tb_state_t next_st;
    logic [WIDTH-1:0] reload_eff;
    logic tick;

    always_comb begin
        next_st = st;
        reload_eff = reload_buffer_enable ? st.reload_act : reload_pre;
        tick = counter_enable && (st.pre_cnt >= st.pre_act);
        overflow = tick && (st.cnt >= reload_eff);
        compare_hit = tick && (st.cnt == st.cmp_act);
        if (counter_enable) begin
            next_st.pre_cnt = tick ? '0 : st.pre_cnt + 1'b1;
            if (tick) begin
                next_st.cnt = overflow ? '0 : st.cnt + 1'b1;
            end
        end
        if (soft_restart) begin
            next_st.pre_cnt = '0;
            next_st.cnt = '0;
        end
        if (update_event) begin
            next_st.reload_act = reload_pre;
            next_st.pre_act = prescale_pre;
            next_st.cmp_act = compare_pre;
        end
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            st <= '0;
        end else if (clk_en) begin
            st <= next_st;
        end
    end

    assign count = st.cnt;

    shadow_hold_a: assert property (@(posedge core_clk) disable iff (!rst_b)
        !update_event |=> $stable(st.pre_act) && $stable(st.cmp_act)
        && $stable(st.reload_act))
        else $error("active copy changed without update");

    stopped_hold_a: assert property (@(posedge core_clk) disable iff (!rst_b)
        clk_en && !counter_enable && !soft_restart |=> $stable(count))
        else $error("counter moved while disabled");

endmodule

// *** hw/tcie_timer.sv ***
// Added by the designer: the AHB-Lite register port.
`timescale 1ns/100ps
`include "tcie_consts.svh"

module tcie_timer
    import tcie_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst_b,
    input wire logic clk_en,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    output logic timer_irq,
    output logic filter_sample_tick,
    output logic [15:0] timer_count
);

    // =====================================================================
    // state
    // =====================================================================
    typedef struct packed {
        tcie_bus_state_t bus;
        tcie_aphase_t ap;
        tcie_ctl_t ctl;
        tcie_ien_t ien;
        logic update_flag;
        logic channel1_flag;
        logic update_generate;
        logic [15:0] prescale_pre;
        logic [15:0] reload_pre;
        logic [15:0] compare_pre;
        logic [31:0] rdata;
    } tcie_state_t;

    tcie_state_t st;
    tcie_state_t next_st;
    logic overflow;
    logic compare_hit;
    logic soft_upd_req;
    logic upd_evt;
    logic [15:0] count;
    logic [15:0] wd;
    logic wr_ok;
    logic wr_now;
    logic rd_now;

    function automatic logic [15:0] low16(input logic [31:0] w);
        low16 = w[15:0];
    endfunction

    function automatic logic is_addr(input logic [11:0] a, input logic [11:0] off);
        is_addr = ({a[11:2], 2'b00} == off);
    endfunction

    // =====================================================================
    // update event
    // =====================================================================
    always_comb begin
        soft_upd_req = st.update_generate;
        upd_evt = !st.ctl.update_disable
            && (overflow || (soft_upd_req && !st.ctl.update_source_select));
    end

    // =====================================================================
    // bus slave and registers
    // =====================================================================
    always_comb begin
        next_st = st;
        wd = low16(hwdata);
        // byte writes are ignored; halfword or word only
        wr_ok = (st.ap.size == 3'h1) || (st.ap.size == 3'h2);
        wr_now = st.ap.sel && st.ap.write && wr_ok;
        rd_now = hsel && hready && htrans[1] && !hwrite;
        next_st.update_generate = 1'b0;
        if (upd_evt) begin
            next_st.update_flag = 1'b1;
        end
        if (compare_hit) begin
            next_st.channel1_flag = 1'b1;
        end
        if (wr_now) begin
            if (is_addr(st.ap.addr, `TCIE_OFF_CONTROL)) begin
                next_st.ctl.filter_clock_divide = wd[`TCIE_CTL_DIV_HI:`TCIE_CTL_DIV_LO];
                next_st.ctl.reload_buffer_enable = wd[`TCIE_CTL_RBUF_BIT];
                next_st.ctl.update_source_select = wd[`TCIE_CTL_USRC_BIT];
                next_st.ctl.update_disable = wd[`TCIE_CTL_NOUPD_BIT];
                next_st.ctl.counter_enable = wd[`TCIE_CTL_RUN_BIT];
            end
            if (is_addr(st.ap.addr, `TCIE_OFF_IRQ_EN)) begin
                next_st.ien.channel1_irq_enable = wd[`TCIE_CH1_BIT];
                next_st.ien.update_irq_enable = wd[`TCIE_UPD_BIT];
            end
            if (is_addr(st.ap.addr, `TCIE_OFF_STATUS)) begin
                // write zero clears; a same-cycle hardware set wins
                next_st.update_flag = (st.update_flag & wd[`TCIE_UPD_BIT]) | upd_evt;
                next_st.channel1_flag = (st.channel1_flag & wd[`TCIE_CH1_BIT]) | compare_hit;
            end
            if (is_addr(st.ap.addr, `TCIE_OFF_EVENT)) begin
                next_st.update_generate = wd[`TCIE_UPD_BIT];
                if (wd[`TCIE_CH1_BIT]) begin
                    next_st.channel1_flag = 1'b1;
                end
            end
            if (is_addr(st.ap.addr, `TCIE_OFF_PRESCALER)) begin
                next_st.prescale_pre = wd;
            end
            if (is_addr(st.ap.addr, `TCIE_OFF_RELOAD)) begin
                next_st.reload_pre = wd;
            end
            if (is_addr(st.ap.addr, `TCIE_OFF_COMPARE1)) begin
                next_st.compare_pre = wd;
            end
        end
        if (rd_now) begin
            next_st.rdata = '0;
            if (is_addr(haddr[11:0], `TCIE_OFF_CONTROL)) begin
                next_st.rdata[15:0] = {6'h00, st.ctl.filter_clock_divide,
                    st.ctl.reload_buffer_enable, 4'h0, st.ctl.update_source_select,
                    st.ctl.update_disable, st.ctl.counter_enable};
            end
            if (is_addr(haddr[11:0], `TCIE_OFF_IRQ_EN)) begin
                next_st.rdata[1:0] = st.ien;
            end
            if (is_addr(haddr[11:0], `TCIE_OFF_STATUS)) begin
                next_st.rdata[1:0] = {st.channel1_flag, st.update_flag};
            end
            if (is_addr(haddr[11:0], `TCIE_OFF_PRESCALER)) begin
                next_st.rdata[15:0] = st.prescale_pre;
            end
            if (is_addr(haddr[11:0], `TCIE_OFF_RELOAD)) begin
                next_st.rdata[15:0] = st.reload_pre;
            end
            if (is_addr(haddr[11:0], `TCIE_OFF_COMPARE1)) begin
                next_st.rdata[15:0] = st.compare_pre;
            end
            if (is_addr(haddr[11:0], `TCIE_OFF_COUNT)) begin
                next_st.rdata[15:0] = count;
            end
        end
        next_st.ap.sel = hsel && hready && htrans[1];
        next_st.ap.write = hwrite;
        next_st.ap.addr = haddr[11:0];
        next_st.ap.size = hsize;
        next_st.bus = next_st.ap.sel ? TCIE_BUS_DATA : TCIE_BUS_IDLE;
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            st <= '0;
            st.bus <= TCIE_BUS_IDLE;
        end else if (clk_en) begin
            st <= next_st;
        end
    end

    // =====================================================================
    // outputs
    // =====================================================================
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign hrdata = st.rdata;
    assign timer_count = count;
    assign timer_irq = (st.update_flag && st.ien.update_irq_enable)
        || (st.channel1_flag && st.ien.channel1_irq_enable);

    // =====================================================================
    // datapath
    // =====================================================================
    tcie_sample_div u_div (
        .core_clk(core_clk),
        .rst_b(rst_b),
        .clk_en(clk_en),
        .filter_clock_divide(st.ctl.filter_clock_divide),
        .sample_tick(filter_sample_tick)
    );

    tcie_time_base #(.WIDTH(16)) u_tb (
        .core_clk(core_clk),
        .rst_b(rst_b),
        .clk_en(clk_en),
        .counter_enable(st.ctl.counter_enable),
        .reload_buffer_enable(st.ctl.reload_buffer_enable),
        .update_event(upd_evt),
        .soft_restart(soft_upd_req),
        .reload_pre(st.reload_pre),
        .prescale_pre(st.prescale_pre),
        .compare_pre(st.compare_pre),
        .overflow(overflow),
        .compare_hit(compare_hit),
        .count(count)
    );

    // =====================================================================
    // checks
    // =====================================================================
    gen_selfclear_a: assert property (@(posedge core_clk) disable iff (!rst_b)
        st.update_generate && clk_en |=> !st.update_generate || $past(wr_now))
        else $error("update generate did not clear");

    gen_pulse_a: assert property (@(posedge core_clk) disable iff (!rst_b)
        st.update_generate && clk_en && !(wr_now && is_addr(st.ap.addr, `TCIE_OFF_EVENT))
        |=> !st.update_generate)
        else $error("update generate stood two cycles");

    gen_restart_a: assert property (@(posedge core_clk) disable iff (!rst_b)
        soft_upd_req && clk_en |=> timer_count == 16'h0)
        else $error("software request did not clear the counter");

    source_overflow_a: assert property (@(posedge core_clk) disable iff (!rst_b)
        soft_upd_req && st.ctl.update_source_select && !overflow |-> !upd_evt)
        else $error("software request made update with source select set");

    source_any_a: assert property (@(posedge core_clk) disable iff (!rst_b)
        soft_upd_req && !st.ctl.update_source_select && !st.ctl.update_disable |-> upd_evt)
        else $error("software request gave no update");

    disable_block_a: assert property (@(posedge core_clk) disable iff (!rst_b)
        st.ctl.update_disable |-> !upd_evt)
        else $error("update while disabled");

    flag_set_a: assert property (@(posedge core_clk) disable iff (!rst_b)
        upd_evt && clk_en |=> st.update_flag)
        else $error("update flag not set");

    status_clear_a: assert property (@(posedge core_clk) disable iff (!rst_b)
        clk_en && wr_now && is_addr(st.ap.addr, `TCIE_OFF_STATUS) && !wd[`TCIE_UPD_BIT]
        && !upd_evt |=> !st.update_flag)
        else $error("update flag not cleared by software");

    flag_hold_a: assert property (@(posedge core_clk) disable iff (!rst_b)
        clk_en && st.update_flag && !(wr_now && is_addr(st.ap.addr, `TCIE_OFF_STATUS))
        |=> st.update_flag)
        else $error("update flag cleared without a status write");

    ch1_set_a: assert property (@(posedge core_clk) disable iff (!rst_b)
        clk_en && compare_hit |=> st.channel1_flag)
        else $error("channel 1 flag not set on match");

    irq_gate_a: assert property (@(posedge core_clk) disable iff (!rst_b)
        !st.ien.update_irq_enable && !st.ien.channel1_irq_enable |-> !timer_irq)
        else $error("interrupt while all enables clear");

    irq_raise_a: assert property (@(posedge core_clk) disable iff (!rst_b)
        st.update_flag && st.ien.update_irq_enable |-> timer_irq)
        else $error("enabled update flag gave no interrupt");

    irq_ch1_a: assert property (@(posedge core_clk) disable iff (!rst_b)
        st.channel1_flag && st.ien.channel1_irq_enable |-> timer_irq)
        else $error("enabled channel 1 flag gave no interrupt");

    irq_low_a: assert property (@(posedge core_clk) disable iff (!rst_b)
        !st.update_flag && !st.channel1_flag |-> !timer_irq)
        else $error("interrupt with no flag set");

    ctl_write_a: assert property (@(posedge core_clk) disable iff (!rst_b)
        clk_en && wr_now && is_addr(st.ap.addr, `TCIE_OFF_CONTROL) |=>
        st.ctl.counter_enable == $past(wd[`TCIE_CTL_RUN_BIT])
        && st.ctl.filter_clock_divide == $past(wd[`TCIE_CTL_DIV_HI:`TCIE_CTL_DIV_LO]))
        else $error("control write did not land");

    ien_write_a: assert property (@(posedge core_clk) disable iff (!rst_b)
        clk_en && wr_now && is_addr(st.ap.addr, `TCIE_OFF_IRQ_EN) |=>
        st.ien == $past(wd[`TCIE_CH1_BIT:`TCIE_UPD_BIT]))
        else $error("interrupt enable write did not land");

    byte_write_a: assert property (@(posedge core_clk) disable iff (!rst_b)
        clk_en && st.ap.sel && st.ap.write && st.ap.size == 3'h0 |=> $stable(st.ctl))
        else $error("byte write changed control");

    rdata_hold_a: assert property (@(posedge core_clk) disable iff (!rst_b)
        clk_en && !rd_now |=> $stable(hrdata))
        else $error("read data changed without a read");

    event_read_a: assert property (@(posedge core_clk) disable iff (!rst_b)
        clk_en && rd_now && is_addr(haddr[11:0], `TCIE_OFF_EVENT) |=> hrdata == 32'h0)
        else $error("event register read not zero");

    bus_state_a: assert property (@(posedge core_clk) disable iff (!rst_b)
        $onehot(st.bus) && hreadyout && !hresp)
        else $error("bus state or response broken");

endmodule

// *** bench/tcie_timer_test.sv ***
`timescale 1ns/100ps
`include "tcie_consts.svh"

module tcie_timer_test;

// ==========================================================
// signals
logic core_clk;
logic rst_b;
logic clk_en;
logic hsel;
logic [31:0] haddr;
logic [1:0] htrans;
logic hwrite;
logic [2:0] hsize;
logic [31:0] hwdata;
wire hready;
logic [31:0] hrdata;
logic hreadyout;
logic hresp;
logic timer_irq;
logic filter_sample_tick;
logic [15:0] timer_count;
int mismatches;
int check_count;
logic [31:0] rdv;
logic [15:0] c1;
logic [15:0] c2;
int cnt;

typedef struct {
    logic [11:0] a;
    logic [2:0] sz;
    logic [31:0] wd;
    logic [31:0] exp;
} tcie_row_t;

tcie_row_t rows [7] = '{
    '{`TCIE_OFF_CONTROL, 3'h2, 32'h00000387, 32'h00000387},
    '{`TCIE_OFF_CONTROL, 3'h1, 32'h00000104, 32'h00000104},
    '{`TCIE_OFF_CONTROL, 3'h1, 32'h00000280, 32'h00000280},
    '{`TCIE_OFF_IRQ_EN, 3'h2, 32'h0000ffff, 32'h00000003},
    '{`TCIE_OFF_IRQ_EN, 3'h1, 32'h00000002, 32'h00000002},
    '{`TCIE_OFF_IRQ_EN, 3'h2, 32'h00000001, 32'h00000001},
    '{12'h03c, 3'h2, 32'h0000ffff, 32'h00000000}
};
int tick_exp [4] = '{16, 8, 4, 16};

assign hready = hreadyout;

tcie_timer DUT (
    .core_clk(core_clk),
    .rst_b(rst_b),
    .clk_en(clk_en),
    .hsel(hsel),
    .haddr(haddr),
    .htrans(htrans),
    .hwrite(hwrite),
    .hsize(hsize),
    .hwdata(hwdata),
    .hready(hready),
    .hrdata(hrdata),
    .hreadyout(hreadyout),
    .hresp(hresp),
    .timer_irq(timer_irq),
    .filter_sample_tick(filter_sample_tick),
    .timer_count(timer_count)
);

// ==========================================================
// clock and watchdog
initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
end

initial begin
    #500000;
    mismatches++;
    end_of_test();
end

// ==========================================================
// helpers
task automatic end_of_test();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) begin
        $display("Testbench passed");
    end else begin
        $display("Testbench failed");
    end
    $finish;
endtask

task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
        mismatches++;
        $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
endtask

// one single transfer, then one idle cycle so a read-back sees the write
task automatic xfer(input logic wr, input logic [11:0] a, input logic [2:0] sz,
                    input logic [31:0] wd);
    int n;
    n = 0;
    hsel <= 1'b1;
    haddr <= {20'h0, a};
    htrans <= 2'b10;
    hwrite <= wr;
    hsize <= sz;
    @(posedge core_clk);
    while (hready !== 1'b1 && n < 100) begin
        n++;
        @(posedge core_clk);
    end
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    @(posedge core_clk);
    while (hready !== 1'b1 && n < 200) begin
        n++;
        @(posedge core_clk);
    end
    rdv = hrdata;
    @(posedge core_clk);
endtask

task automatic wr(input logic [11:0] a, input logic [31:0] d);
    xfer(1'b1, a, 3'h2, d);
endtask

task automatic rdc(input logic [11:0] a, input logic [31:0] exp);
    xfer(1'b0, a, 3'h2, 32'h0);
    chk(rdv, exp);
endtask

task automatic idle(input int n);
    repeat (n) @(posedge core_clk);
endtask

// interrupt line looked at mid-cycle, once the last edge has settled
task automatic chk_irq(input logic exp);
    @(negedge core_clk);
    chk({31'h0, timer_irq}, {31'h0, exp});
    @(posedge core_clk);
endtask

task automatic cnt_now(output logic [15:0] v);
    @(negedge core_clk);
    v = timer_count;
    @(posedge core_clk);
endtask

// highest count seen over n cycles
task automatic peak(input int n, output logic [15:0] mx);
    mx = 16'h0;
    repeat (n) begin
        @(negedge core_clk);
        if (timer_count > mx) mx = timer_count;
    end
    @(posedge core_clk);
endtask

// ==========================================================
// main sequence
initial begin
    mismatches = 0;
    check_count = 0;
    rst_b = 1'b0;
    clk_en = 1'b1;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'h0;
    hwdata = 32'h0;
    repeat (20) @(posedge core_clk);
    rst_b <= 1'b1;
    @(posedge core_clk);
    rdc(`TCIE_OFF_CONTROL, 32'h0);
    rdc(`TCIE_OFF_IRQ_EN, 32'h0);
    chk_irq(1'b0);
    chk({31'h0, hresp}, 32'h0);
    for (int i = 0; i < 7; i++) begin
        xfer(1'b1, rows[i].a, rows[i].sz, rows[i].wd);
        rdc(rows[i].a, rows[i].exp);
    end
    xfer(1'b0, `TCIE_OFF_CONTROL, 3'h0, 32'h0);
    chk(rdv, 32'h280);
    xfer(1'b1, `TCIE_OFF_CONTROL, 3'h0, 32'h1);
    rdc(`TCIE_OFF_CONTROL, 32'h280);
    for (int c = 0; c < 4; c++) begin
        wr(`TCIE_OFF_CONTROL, c << 8);
        cnt = 0;
        repeat (16) begin
            @(negedge core_clk);
            if (filter_sample_tick === 1'b1) cnt++;
        end
        @(posedge core_clk);
        chk(cnt, tick_exp[c]);
    end
    // counter run, stop and software updates
    wr(`TCIE_OFF_IRQ_EN, 32'h0);
    wr(`TCIE_OFF_COMPARE1, 32'h1234);
    wr(`TCIE_OFF_RELOAD, 32'h00ff);
    wr(`TCIE_OFF_PRESCALER, 32'h0);
    wr(`TCIE_OFF_EVENT, 32'h1);
    wr(`TCIE_OFF_STATUS, 32'h0);
    wr(`TCIE_OFF_CONTROL, 32'h1);
    idle(10);
    wr(`TCIE_OFF_CONTROL, 32'h0);
    cnt_now(c1);
    idle(5);
    cnt_now(c2);
    chk(c2, c1);
    chk(c1 == 16'h0, 32'h0);
    wr(`TCIE_OFF_CONTROL, 32'h2);
    wr(`TCIE_OFF_EVENT, 32'h1);
    idle(3);
    cnt_now(c1);
    chk(c1, 32'h0);
    rdc(`TCIE_OFF_STATUS, 32'h0);
    wr(`TCIE_OFF_CONTROL, 32'h4);
    wr(`TCIE_OFF_EVENT, 32'h1);
    idle(3);
    rdc(`TCIE_OFF_STATUS, 32'h0);
    wr(`TCIE_OFF_CONTROL, 32'h0);
    wr(`TCIE_OFF_EVENT, 32'h1);
    idle(3);
    rdc(`TCIE_OFF_STATUS, 32'h1);
    rdc(`TCIE_OFF_EVENT, 32'h0);
    chk_irq(1'b0);
    wr(`TCIE_OFF_IRQ_EN, 32'h1);
    chk_irq(1'b1);
    wr(`TCIE_OFF_STATUS, 32'h0);
    chk_irq(1'b0);
    wr(`TCIE_OFF_EVENT, 32'h2);
    idle(3);
    rdc(`TCIE_OFF_STATUS, 32'h2);
    chk_irq(1'b0);
    wr(`TCIE_OFF_IRQ_EN, 32'h2);
    chk_irq(1'b1);
    wr(`TCIE_OFF_STATUS, 32'h0);
    chk_irq(1'b0);
    // reload buffering and overflow updates
    wr(`TCIE_OFF_RELOAD, 32'h3);
    wr(`TCIE_OFF_EVENT, 32'h1);
    wr(`TCIE_OFF_CONTROL, 32'h83);
    wr(`TCIE_OFF_RELOAD, 32'h7);
    peak(40, c1);
    chk(c1, 32'h3);
    wr(`TCIE_OFF_CONTROL, 32'h81);
    peak(40, c1);
    chk(c1, 32'h7);
    wr(`TCIE_OFF_STATUS, 32'h0);
    idle(20);
    rdc(`TCIE_OFF_STATUS, 32'h1);
    wr(`TCIE_OFF_CONTROL, 32'h85);
    wr(`TCIE_OFF_STATUS, 32'h0);
    idle(20);
    rdc(`TCIE_OFF_STATUS, 32'h1);
    wr(`TCIE_OFF_CONTROL, 32'h1);
    wr(`TCIE_OFF_RELOAD, 32'ha);
    peak(40, c1);
    chk(c1, 32'ha);
    // clock enable low freezes the running counter
    clk_en <= 1'b0;
    cnt_now(c1);
    idle(5);
    cnt_now(c2);
    chk(c2, c1);
    clk_en <= 1'b1;
    idle(3);
    cnt_now(c2);
    chk(c2 != c1, 32'h1);
    // prescaler of one: the counter steps every second clock after the restart
    wr(`TCIE_OFF_PRESCALER, 32'h1);
    wr(`TCIE_OFF_EVENT, 32'h1);
    idle(20);
    cnt_now(c1);
    chk(c1, 32'ha);
    // reset in mid-run
    rst_b <= 1'b0;
    idle(2);
    rst_b <= 1'b1;
    @(posedge core_clk);
    rdc(`TCIE_OFF_CONTROL, 32'h0);
    rdc(`TCIE_OFF_IRQ_EN, 32'h0);
    cnt_now(c1);
    chk(c1, 32'h0);
    end_of_test();
end

endmodule
